// ==== design/host_bus_autodetect_port.sv ====
// Host bus port with strobe and bus style detection and RAM access.
`timescale 1ns/100ps
module host_bus_autodetect_port #(
	parameter int RAM_DEPTH = 2048,
	parameter int RAM_AW    = 11
)(
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              rst_n,
	// Host pins
	input  wire logic              chip_select_low,
	input  wire logic              read_strobe_low,
	input  wire logic              write_strobe_low,
	input  wire logic [2:0]        register_select_lines,
	input  wire logic [7:0]        data_in,
	output logic      [7:0]        data_out,
	output logic                   data_oe,
	// Mode control and detection results
	input  wire logic              fast_read_enable,
	output logic                   strobe_style_ds,
	output logic                   bus_non_multiplexed,
	output logic                   styles_frozen,
	// Core register side
	input  wire logic [7:0]        status_value,
	input  wire logic [7:0]        diagnostic_status_reg_set,
	input  wire logic [7:0]        next_node_id,
	input  wire logic [7:0]        sub_reg_value,
	output logic                   next_node_read,
	output logic                   reg_write,
	output logic      [2:0]        reg_write_addr,
	output logic      [7:0]        reg_write_data,
	// Core RAM port, served ahead of the host
	input  wire logic              core_ram_en,
	input  wire logic              core_ram_we,
	input  wire logic [RAM_AW-1:0] core_ram_addr,
	input  wire logic [7:0]        core_ram_wdata,
	output logic      [7:0]        core_ram_rdata
);
	localparam int PW = host_port_pkg::PIN_W;
	logic [PW-1:0]         pin_meta;
	logic [PW-1:0]         pin_sync;
	logic                  cs_s;
	logic                  rd_s;
	logic                  wr_s;
	logic [2:0]            addr_s;
	logic [7:0]            data_s;
	logic                  a0_prev;
	logic                  style_known;
	logic [2:0]            mux_addr;
	logic [2:0]            eff_addr;
	logic                  rd_level;
	logic                  wr_level;
	logic                  wr_prev;
	logic [2:0]            wr_addr;
	logic [7:0]            wr_data;
	logic                  wr_done;
	logic [host_port_pkg::COUNT_W-1:0] rd_count;
	logic [host_port_pkg::COUNT_W-1:0] sample_at;
	logic [host_port_pkg::COUNT_W-1:0] start_at;
	logic                  smp_cs;
	logic [2:0]            smp_addr;
	logic                  read_start;
	logic                  internal_read;
	logic [7:0]            diagnostic_status_reg;
	logic [7:0]            data_reg;
	logic [RAM_AW-1:0]     ptr;
	logic                  read_dir;
	logic                  auto_inc;
	logic                  fetch_pending;
	logic                  commit_pending;
	logic                  host_slot;
	logic [7:0]            mem [RAM_DEPTH];
	logic                  raw_read;
	logic [2:0]            raw_addr;
	// Two flip-flops ahead of the logic that looks at the host pins, all but the output path
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_meta <= '1;
			pin_sync <= '1;
		end
		else
		begin
			pin_meta <= {chip_select_low, read_strobe_low,
				write_strobe_low, register_select_lines, data_in};
			pin_sync <= pin_meta;
		end
	end
	assign cs_s   = pin_sync[13];
	assign rd_s   = pin_sync[12];
	assign wr_s   = pin_sync[11];
	assign addr_s = pin_sync[10:8];
	assign data_s = pin_sync[7:0];
	// Strobe style: on the first write, read pin low too means direction
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			strobe_style_ds <= 1'b0;
			style_known     <= 1'b0;
		end
		else if (!style_known && !styles_frozen && !cs_s && !wr_s)
		begin
			strobe_style_ds <= !rd_s;
			style_known     <= 1'b1;
		end
	end

	// Bus style: any movement of the lowest line in an access means non-mux
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			a0_prev             <= 1'b0;
			bus_non_multiplexed <= 1'b0;
		end
		else
		begin
			a0_prev <= addr_s[0];
			if (!styles_frozen && !cs_s && (addr_s[0] != a0_prev))
				bus_non_multiplexed <= 1'b1;
		end
	end

	// Read and write levels in the style now in force
	assign rd_level = !cs_s && (strobe_style_ds ? (!wr_s && rd_s) : !rd_s);
	assign wr_level = !cs_s && (strobe_style_ds ? (!wr_s && !rd_s) : !wr_s);
	// Freeze waits for the style: a direction write first looks like a read
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			styles_frozen <= 1'b0;
		else if (rd_level && style_known)
			styles_frozen <= 1'b1;
	end

	// Multiplexed bus: address is taken off the data lines between strobes
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			mux_addr <= 3'h0;
		else if (!rd_level && !wr_level)
			mux_addr <= data_s[2:0];
	end
	assign eff_addr = bus_non_multiplexed ? addr_s : mux_addr;
	// Strobe age counter, saturating, cleared the moment the strobe ends
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			rd_count <= host_port_pkg::CNT_ZERO;
		else if (!rd_level)
			rd_count <= host_port_pkg::CNT_ZERO;
		else if (rd_count != host_port_pkg::CNT_MAX)
			rd_count <= rd_count + host_port_pkg::CNT_ONE;
	end

	// Fast mode waits out both delay stages; the host stretches the strobe
	assign sample_at = fast_read_enable ? host_port_pkg::FAST_SAMPLE_AT
		: host_port_pkg::CNT_ZERO;
	assign start_at  = fast_read_enable ? host_port_pkg::FAST_START_AT
		: host_port_pkg::CNT_ONE;

	// Selects and chip select caught once, so side effects see stable values
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			smp_cs   <= 1'b0;
			smp_addr <= 3'h0;
		end
		else if (rd_level && rd_count == sample_at)
		begin
			smp_cs   <= !cs_s;
			smp_addr <= eff_addr;
		end
	end

	// Read pulse starts late but ends with the strobe itself
	assign internal_read = rd_level && smp_cs && (rd_count >= start_at);
	assign read_start    = internal_read && (rd_count == start_at);
	// Write is acted on at its end, using the last values seen in it
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_prev <= 1'b0;
			wr_addr <= 3'h0;
			wr_data <= host_port_pkg::BYTE_ZERO;
		end
		else
		begin
			wr_prev <= wr_level;
			if (wr_level)
			begin
				wr_addr <= eff_addr;
				wr_data <= data_s;
			end
		end
	end
	assign wr_done = wr_prev && !wr_level;
	// Every write, pointer and data registers included, goes straight on to the core
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			reg_write      <= 1'b0;
			reg_write_addr <= 3'h0;
			reg_write_data <= host_port_pkg::BYTE_ZERO;
		end
		else
		begin
			reg_write <= wr_done;
			if (wr_done)
			begin
				reg_write_addr <= wr_addr;
				reg_write_data <= wr_data;
			end
		end
	end

	// Diagnostic flags: a core event in the clearing cycle survives
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			diagnostic_status_reg <= host_port_pkg::DIAGNOSTIC_STATUS_REG_RESET;
		else if (read_start && smp_addr == host_port_pkg::OFS_DIAGNOSTIC_STATUS_REG)
			diagnostic_status_reg <= diagnostic_status_reg_set;
		else
			diagnostic_status_reg <= diagnostic_status_reg | diagnostic_status_reg_set;
	end

	// Next-node read notice for the core
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			next_node_read <= 1'b0;
		else
			next_node_read <= read_start
				&& smp_addr == host_port_pkg::OFS_NEXT_ID;
	end
	// Host gets the RAM only in cycles the core leaves free
	assign host_slot = !core_ram_en;
	// Pointer: loaded by host, stepped by commits and data reads
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ptr      <= '0;
			read_dir <= 1'b0;
			auto_inc <= 1'b0;
		end
		else if (wr_done && wr_addr == host_port_pkg::OFS_PTR_HIGH)
		begin
			read_dir <= wr_data[host_port_pkg::BIT_READ_DIR];
			auto_inc <= wr_data[host_port_pkg::BIT_AUTO_INC];
			ptr[RAM_AW-1:8] <= wr_data[host_port_pkg::PTR_HIGH_W-1:0];
		end
		else if (wr_done && wr_addr == host_port_pkg::OFS_PTR_LOW)
			ptr[7:0] <= wr_data;
		else if (auto_inc && read_start
			&& smp_addr == host_port_pkg::OFS_DATA)
			ptr <= ptr + 1'b1;
		else if (auto_inc && commit_pending && host_slot)
			ptr <= ptr + 1'b1;
	end

	// Fetch requests: pointer low write for reads, or a stepping data read
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			fetch_pending <= 1'b0;
		else if (wr_done && wr_addr == host_port_pkg::OFS_PTR_LOW && read_dir)
			fetch_pending <= 1'b1;
		else if (auto_inc && read_start
			&& smp_addr == host_port_pkg::OFS_DATA)
			fetch_pending <= 1'b1;
		else if (host_slot && !commit_pending)
			fetch_pending <= 1'b0;
	end

	// Commit request after a data register write
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			commit_pending <= 1'b0;
		else if (wr_done && wr_addr == host_port_pkg::OFS_DATA)
			commit_pending <= 1'b1;
		else if (host_slot)
			commit_pending <= 1'b0;
	end

	// Data register: host byte first, prefetched RAM byte otherwise
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			data_reg <= host_port_pkg::DATA_RESET;
		else if (wr_done && wr_addr == host_port_pkg::OFS_DATA)
			data_reg <= wr_data;
		else if (fetch_pending && host_slot && !commit_pending)
			data_reg <= mem[ptr];
	end

	// RAM array; no reset, the core initialises buffers it uses
	always_ff @(posedge clock)
	begin
		if (core_ram_en && core_ram_we)
			mem[core_ram_addr] <= core_ram_wdata;
		else if (commit_pending && host_slot)
			mem[ptr] <= data_reg;
	end

	// Core read port
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			core_ram_rdata <= host_port_pkg::BYTE_ZERO;
		else if (core_ram_en)
			core_ram_rdata <= mem[core_ram_addr];
	end

	// Output path uses the raw pins so access time is not lost
	assign raw_read = !chip_select_low && (strobe_style_ds
		? (!write_strobe_low && read_strobe_low)
		: !read_strobe_low);
	assign raw_addr = bus_non_multiplexed ? register_select_lines
		: mux_addr;
	assign data_oe  = raw_read;

	// Direct decode of register offsets; RAM only via the data register
	always_comb
	begin
		unique case (raw_addr)
			host_port_pkg::OFS_STATUS:   data_out = status_value;
			host_port_pkg::OFS_DIAGNOSTIC_STATUS_REG:     data_out = diagnostic_status_reg;
			host_port_pkg::OFS_PTR_HIGH: data_out = {read_dir, auto_inc,
				{(8 - 2 - host_port_pkg::PTR_HIGH_W){1'b0}},
				ptr[RAM_AW-1:8]};
			host_port_pkg::OFS_PTR_LOW:  data_out = ptr[7:0];
			host_port_pkg::OFS_DATA:     data_out = data_reg;
			host_port_pkg::OFS_NEXT_ID:  data_out = next_node_id;
			default:                     data_out = sub_reg_value;
		endcase
	end

endmodule // host_bus_autodetect_port

// ==== design/host_port_pkg.sv ====
// Constants shared by the host bus port: offsets, fields and timing.
package host_port_pkg;
	// Register offsets on the three select lines
	localparam logic [2:0] OFS_STATUS   = 3'h0;
	localparam logic [2:0] OFS_DIAGNOSTIC_STATUS_REG     = 3'h1;
	localparam logic [2:0] OFS_PTR_HIGH = 3'h2;
	localparam logic [2:0] OFS_PTR_LOW  = 3'h3;
	localparam logic [2:0] OFS_DATA     = 3'h4;
	localparam logic [2:0] OFS_NEXT_ID  = 3'h7;
	// Pointer high byte fields
	localparam int BIT_READ_DIR = 7;
	localparam int BIT_AUTO_INC = 6;
	localparam int PTR_HIGH_W   = 3;
	// Reset values
	localparam logic [7:0] DIAGNOSTIC_STATUS_REG_RESET  = 8'h00;
	localparam logic [7:0] DATA_RESET  = 8'h00;
	localparam logic [7:0] BYTE_ZERO   = 8'h00;
	// Read strobe delays, in ns, and the clock period
	localparam int CLOCK_NS        = 8;
	localparam int READ_DELAY1_NS  = 15;
	localparam int READ_DELAY2_NS  = 10;
	// Least delays round up to whole cycles
	localparam int READ_DELAY1_CYC =
		(READ_DELAY1_NS + CLOCK_NS - 1) / CLOCK_NS;
	localparam int READ_DELAY2_CYC =
		(READ_DELAY2_NS + CLOCK_NS - 1) / CLOCK_NS;
	localparam int COUNT_W = 3;
	localparam logic [COUNT_W-1:0] CNT_ZERO = 3'h0;
	localparam logic [COUNT_W-1:0] CNT_ONE  = 3'h1;
	localparam logic [COUNT_W-1:0] CNT_MAX  = 3'h7;
	localparam logic [COUNT_W-1:0] FAST_SAMPLE_AT =
		COUNT_W'(READ_DELAY1_CYC);
	localparam logic [COUNT_W-1:0] FAST_START_AT =
		COUNT_W'(READ_DELAY1_CYC + READ_DELAY2_CYC);
	// Width of the synchronised pin bundle
	localparam int PIN_W = 14;
endpackage

// ==== test/host_port_checker.sv ====
// Concurrent checks on the host port pins and detection flags.
`timescale 1ns/100ps
module host_port_checker (
	// Clock and reset
	input wire logic       clock,
	input wire logic       rst_n,
	// Host pins
	input wire logic       chip_select_low,
	input wire logic       read_strobe_low,
	input wire logic       write_strobe_low,
	input wire logic [2:0] register_select_lines,
	input wire logic       data_oe,
	// Detection results and core pulses
	input wire logic       strobe_style_ds,
	input wire logic       bus_non_multiplexed,
	input wire logic       styles_frozen,
	input wire logic       next_node_read,
	input wire logic       reg_write
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	// Host strobe stays idle after a write has been handed on
	sequence write_idle;
		write_strobe_low [*2];
	endsequence
	// Core pulse lasts exactly one cycle
	sequence next_pulse;
		next_node_read ##1 !next_node_read;
	endsequence

	// Drive enable uses raw pins, so read access time is not lost
	oe_from_pins_a: assert property (data_oe == (!chip_select_low &&
		(strobe_style_ds ? (read_strobe_low && !write_strobe_low)
		: !read_strobe_low)))
		else $error("data enable disagrees with host pins");
	freeze_cause_a: assert property ($rose(styles_frozen) |->
		$past(!chip_select_low, 2) &&
		$past(!read_strobe_low || !write_strobe_low, 2))
		else $error("styles froze without a selected strobe");
	frozen_stays_a: assert property (styles_frozen |=> styles_frozen)
		else $error("freeze flag dropped before reset");
	style_kept_a: assert property (styles_frozen |=> $stable(strobe_style_ds))
		else $error("strobe style changed after freeze");
	mux_kept_a: assert property (
		styles_frozen |=> $stable(bus_non_multiplexed))
		else $error("bus style changed after freeze");
	write_after_end_a: assert property (reg_write |-> write_idle)
		else $error("write handed on while strobe still active");
	write_once_a: assert property (reg_write |=> !reg_write)
		else $error("write pulse longer than one cycle");
	next_cause_a: assert property (next_node_read |->
		!chip_select_low &&
		register_select_lines == host_port_pkg::OFS_NEXT_ID)
		else $error("next node pulse without a read of its offset");
	next_once_a: assert property (next_node_read |-> next_pulse)
		else $error("next node pulse longer than one cycle");
endmodule // host_port_checker

bind host_bus_autodetect_port host_port_checker host_port_checker_i (
	.clock, .rst_n, .chip_select_low, .read_strobe_low,
	.write_strobe_low, .register_select_lines, .data_oe,
	.strobe_style_ds, .bus_non_multiplexed, .styles_frozen,
	.next_node_read, .reg_write);

// ==== test/host_model.sv ====
// Host processor model driving the parallel port pins.
`timescale 1ns/100ps
module host_model (
	// Clock
	input wire logic        clock,
	// Host pins
	output logic            chip_select_low,
	output logic            read_strobe_low,
	output logic            write_strobe_low,
	output logic      [2:0] register_select_lines,
	output logic      [7:0] data_in,
	input  wire logic [7:0] data_out
);
	logic ds_style;
	logic mux_bus;

	// Idle bus until the first access
	initial
	begin
		ds_style = 1'b0;
		mux_bus = 1'b0;
		chip_select_low = 1'b1;
		read_strobe_low = 1'b1;
		write_strobe_low = 1'b1;
		register_select_lines = 3'h0;
		data_in = 8'h00;
	end

	// One access; the strobe lasts len cycles, and the 8 that wr and rd pass is long enough for fast reads
	task automatic access(input logic rd, input logic [2:0] addr,
		input logic [7:0] wdata, input int len, output logic [7:0] rdata);
		@(negedge clock);
		chip_select_low = 1'b0;
		if (ds_style)
			read_strobe_low = rd; // Direction line, high for a read
		// Lowest line moves unless the host multiplexes
		register_select_lines = mux_bus ? 3'h0 : addr ^ 3'h1;
		data_in = {5'h00, addr};
		repeat (3) @(negedge clock);
		register_select_lines = mux_bus ? 3'h0 : addr;
		if (!rd)
			data_in = wdata;
		if (ds_style || !rd)
			write_strobe_low = 1'b0;
		else
			read_strobe_low = 1'b0;
		@(negedge clock);
		rdata = data_out;
		repeat (len - 1) @(negedge clock); // Stretched strobe
		write_strobe_low = 1'b1;
		if (!ds_style)
			read_strobe_low = 1'b1;
		// Select, address and data held one cycle past the strobe
		@(negedge clock);
		chip_select_low = 1'b1;
		read_strobe_low = 1'b1;
		register_select_lines = 3'h0; // Parked low between accesses
		data_in = ~data_in; // Released bus never keeps the last byte
		repeat (4) @(negedge clock);
	endtask
endmodule // host_model

// ==== test/host_bus_autodetect_port_tb.sv ====
// Self-checking bench for the host bus port driven by a host model.
`timescale 1ns/100ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; \
	$display("wrong value at %0t: %h vs %h", $time, (a), (e)); end end
module host_bus_autodetect_port_tb;
	// Pins and core side signals
	logic        clock;
	logic        rst_n;
	logic        chip_select_low;
	logic        read_strobe_low;
	logic        write_strobe_low;
	logic [2:0]  register_select_lines;
	logic [7:0]  data_in;
	logic [7:0]  data_out;
	logic        fast_read_enable;
	logic        strobe_style_ds;
	logic        bus_non_multiplexed;
	logic        styles_frozen;
	logic [7:0]  diagnostic_status_reg_set;
	logic        next_node_read;
	logic        reg_write;
	logic [2:0]  reg_write_addr;
	logic [7:0]  reg_write_data;
	logic        core_ram_en;
	logic        core_ram_we;
	logic [10:0] core_ram_addr;
	logic [7:0]  core_ram_wdata;
	logic [7:0]  core_ram_rdata;
	int          errors;
	int          num_checks;
	int          n_wr;
	int          n_next;

	host_bus_autodetect_port host_bus_autodetect_port_i (
		.clock, .rst_n, .chip_select_low, .read_strobe_low,
		.write_strobe_low, .register_select_lines, .data_in, .data_out,
		.data_oe(), .fast_read_enable, .strobe_style_ds,
		.bus_non_multiplexed, .styles_frozen, .status_value(8'h5C),
		.diagnostic_status_reg_set, .next_node_id(8'h2D), .sub_reg_value(8'hB6),
		.next_node_read, .reg_write, .reg_write_addr, .reg_write_data,
		.core_ram_en, .core_ram_we, .core_ram_addr, .core_ram_wdata,
		.core_ram_rdata);
	host_model host_model_i (
		.clock, .chip_select_low, .read_strobe_low, .write_strobe_low,
		.register_select_lines, .data_in, .data_out);

	task automatic give_verdict;
		if (errors == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		logic [7:0] x;
		host_model_i.access(1'b0, a, d, 8, x);
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		logic [7:0] x;
		host_model_i.access(1'b1, a, 8'h00, 8, x);
		`CHK(x, e)
	endtask
	task automatic do_reset;
		@(negedge clock);
		rst_n = 1'b0;
		repeat (5) @(negedge clock);
		rst_n = 1'b1;
		@(negedge clock);
	endtask
	task automatic flag_diagnostic_status_reg;
		@(negedge clock);
		diagnostic_status_reg_set = 8'h04;
		@(negedge clock);
		diagnostic_status_reg_set = 8'h00;
	endtask
	task automatic core_op(input logic we, input logic [10:0] a,
		input logic [7:0] d);
		@(negedge clock);
		core_ram_en = 1'b1;
		core_ram_we = we;
		core_ram_addr = a;
		core_ram_wdata = d;
		@(negedge clock);
		core_ram_en = 1'b0;
	endtask

	// Defaults, then one odd write and one odd read settle both styles
	task automatic test_detect;
		`CHK(strobe_style_ds, 1'b0)
		`CHK(bus_non_multiplexed, 1'b0)
		wr(3'h5, 8'h3C);
		`CHK(bus_non_multiplexed, 1'b1)
		`CHK(styles_frozen, 1'b0)
		`CHK(reg_write_data, 8'h3C)
		`CHK(reg_write_addr, 3'h5)
		`CHK(n_wr, 1)
		rd(3'h7, 8'h2D);
		`CHK(styles_frozen, 1'b1)
		`CHK(strobe_style_ds, 1'b0)
		`CHK(n_next, 1)
	endtask
	// Auto-increment fill and empty through the pointer
	task automatic test_ram_seq;
		wr(3'h2, 8'h41);
		wr(3'h3, 8'h20);
		wr(3'h4, 8'hA5);
		wr(3'h4, 8'h5A);
		wr(3'h2, 8'hC1);
		wr(3'h3, 8'h20);
		rd(3'h4, 8'hA5);
		rd(3'h4, 8'h5A);
		rd(3'h0, 8'h5C);
		rd(3'h6, 8'hB6);
		core_op(1'b0, 11'h120, 8'h00);
		`CHK(core_ram_rdata, 8'hA5)
	endtask
	// Fixed pointer: data reads alone never refresh the byte
	task automatic test_ram_random;
		wr(3'h2, 8'h81);
		wr(3'h3, 8'h21);
		rd(3'h4, 8'h5A);
		core_op(1'b1, 11'h121, 8'h77);
		rd(3'h4, 8'h5A);
		wr(3'h3, 8'h21);
		rd(3'h4, 8'h77);
	endtask
	// Short strobe clears in normal mode but is ignored in fast mode
	task automatic test_diagnostic_status_reg_modes;
		logic [7:0] x;
		for (int m = 0; m < 2; m++)
		begin
			fast_read_enable = m[0];
			flag_diagnostic_status_reg();
			host_model_i.access(1'b1, 3'h1, 8'h00, 3, x);
			`CHK(x, 8'h04)
			rd(3'h1, m[0] ? 8'h04 : 8'h00);
			rd(3'h1, 8'h00);
		end
		fast_read_enable = 1'b0;
	endtask
	// Direction plus data strobe host after a second reset
	task automatic test_direction_style;
		do_reset();
		host_model_i.ds_style = 1'b1;
		wr(3'h5, 8'h11);
		`CHK(strobe_style_ds, 1'b1)
		fast_read_enable = 1'b1;
		flag_diagnostic_status_reg();
		rd(3'h1, 8'h04);
		`CHK(styles_frozen, 1'b1)
		rd(3'h1, 8'h00);
	endtask
	// Multiplexed host: address rides the data lines, lowest line held low
	task automatic test_mux_bus;
		do_reset();
		host_model_i.ds_style = 1'b0;
		host_model_i.mux_bus = 1'b1;
		wr(3'h5, 8'h22);
		`CHK(bus_non_multiplexed, 1'b0)
		`CHK(reg_write_addr, 3'h5)
		rd(3'h5, 8'hB6);
		`CHK(styles_frozen, 1'b1)
		`CHK(bus_non_multiplexed, 1'b0)
	endtask

	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	// Watchdog well beyond the 513 or so cycles the run needs
	initial
	begin
		#100000;
		errors++;
		give_verdict();
	end
	// Count core side pulses
	always @(posedge clock)
	begin
		if (reg_write)
			n_wr++;
		if (next_node_read)
			n_next++;
	end
	// Main sequence
	initial
	begin
		errors = 0;
		num_checks = 0;
		n_wr = 0;
		n_next = 0;
		rst_n = 1'b0;
		fast_read_enable = 1'b0;
		diagnostic_status_reg_set = 8'h00;
		core_ram_en = 1'b0;
		core_ram_we = 1'b0;
		core_ram_addr = 11'h000;
		core_ram_wdata = 8'h00;
		repeat (5) @(negedge clock);
		rst_n = 1'b1;
		@(negedge clock);
		test_detect();
		test_ram_seq();
		test_ram_random();
		test_diagnostic_status_reg_modes();
		test_direction_style();
		test_mux_bus();
		give_verdict();
	end
endmodule // host_bus_autodetect_port_tb
